/* File: design/ccb_pkg_enc.sv */
/*
 * package of constants for the card column buffer, and the seven-to-three
 * zone encoder used on the compressed read path.
 * assumes a single clock domain; the encoder is purely combinational.
 */
package ccb_pkg;
    localparam int          ZONE_W        = 12;
    localparam int          DATA_W        = 16;
    localparam int          MAINT_W       = 4;
    localparam int          HI_ZONES      = 5;
    localparam int          LO_ZONES      = 7;
    localparam int          ENC_W         = 3;
    localparam logic [1:0]  ADDR_IMAGE    = 2'h0;
    localparam logic [1:0]  ADDR_COMP     = 2'h1;
    localparam logic [1:0]  ADDR_MAINT    = 2'h2;
    localparam int          MNT_TEST_BIT  = 0;
    localparam int          MNT_STRB_BIT  = 1;
    localparam int          MNT_ZONE_LSB  = 4;
    localparam logic [ZONE_W-1:0]  BUF_RST   = 12'h000;
    localparam logic [MAINT_W-1:0] MAINT_RST = 4'h0;
    localparam logic [DATA_W-1:0]  DATA_RST  = 16'h0000;
endpackage : ccb_pkg

`timescale 1ns/1ps
module ccb_zone_encoder (
    input  wire logic [6:0] zones_lo,
    output logic      [2:0] code
);
    // bit 6 is zone 1 ... bit 0 is zone 7; none marked gives 0
    always_comb begin
        code = 3'h0;
        for (int k = 0; k < ccb_pkg::LO_ZONES; k++) begin
            if (zones_lo[k]) begin
                code = 3'(ccb_pkg::LO_ZONES - k);
            end
        end
    end
endmodule : ccb_zone_encoder

/* File: design/ccb_column_buffer.sv */
/*
 * column data path of a card reader controller: pin capture of the
 * zone lines on the column strobe, the column buffer, column-ready flag,
 * image and compressed reads, and the maintenance register.
 * assumes overrun and eject state come from status logic on SYS_CLK.
 */
`timescale 1ns/1ps
module ccb_column_buffer (
    input  wire logic                         SYS_CLK,
    input  wire logic                         RST,
    input  wire logic                         CE,
    input  wire logic [ccb_pkg::ZONE_W-1:0]   ZONE_IN,
    input  wire logic                         COLUMN_STROBE,
    input  wire logic                         OVERRUN_ERROR,
    input  wire logic                         EJECT_PENDING,
    input  wire logic                         HOST_RD,
    input  wire logic                         HOST_WR,
    input  wire logic [1:0]                   HOST_ADDR,
    input  wire logic [ccb_pkg::DATA_W-1:0]   HOST_WDATA,
    output logic      [ccb_pkg::DATA_W-1:0]   HOST_RDATA,
    output logic                              HOST_RVALID,
    output logic                              COLUMN_READY,
    output logic      [ccb_pkg::MAINT_W-1:0]  MAINT_OUT
);
    logic [ccb_pkg::ZONE_W-1:0]  zone_s1_q, zone_s2_q, buf_q;
    logic                        strb_s1_q, strb_s2_q, strb_s3_q;
    logic [ccb_pkg::MAINT_W-1:0] maint_q;
    logic                        inj_q;
    logic [ccb_pkg::ZONE_W-1:0]  inj_zone_q;
    logic                        pin_edge, strobe, load, data_acc;
    logic [ccb_pkg::ZONE_W-1:0]  zone_src;
    logic [2:0]                  enc;

    // pin synchronisers
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            zone_s1_q <= ccb_pkg::BUF_RST;
            zone_s2_q <= ccb_pkg::BUF_RST;
            strb_s1_q <= 1'b0;
            strb_s2_q <= 1'b0;
            strb_s3_q <= 1'b0;
        end else if (CE) begin
            zone_s1_q <= ZONE_IN;
            zone_s2_q <= zone_s1_q;
            strb_s1_q <= COLUMN_STROBE;
            strb_s2_q <= strb_s1_q;
            strb_s3_q <= strb_s2_q;
        end
    end

    assign pin_edge = strb_s2_q & ~strb_s3_q;

    // maintenance register and injected test column
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            maint_q    <= ccb_pkg::MAINT_RST;
            inj_q      <= 1'b0;
            inj_zone_q <= ccb_pkg::BUF_RST;
        end else if (CE) begin
            inj_q <= 1'b0;
            if (HOST_WR && HOST_ADDR == ccb_pkg::ADDR_MAINT) begin
                maint_q    <= HOST_WDATA[ccb_pkg::MAINT_W-1:0];
                inj_q      <= HOST_WDATA[ccb_pkg::MNT_TEST_BIT]
                              & HOST_WDATA[ccb_pkg::MNT_STRB_BIT];
                inj_zone_q <= HOST_WDATA[ccb_pkg::MNT_ZONE_LSB +: ccb_pkg::ZONE_W];
            end
        end
    end

    // test mode replaces the reader pins
    always_comb begin
        if (maint_q[ccb_pkg::MNT_TEST_BIT]) begin
            strobe   = inj_q;
            zone_src = inj_zone_q;
        end else begin
            strobe   = pin_edge;
            zone_src = zone_s2_q;
        end
    end

    assign load     = strobe & ~OVERRUN_ERROR;
    assign data_acc = HOST_RD && (HOST_ADDR == ccb_pkg::ADDR_IMAGE
                                  || HOST_ADDR == ccb_pkg::ADDR_COMP);

    // column buffer
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            buf_q <= ccb_pkg::BUF_RST;
        end else if (CE && load) begin
            buf_q <= zone_src;
        end
    end

    // column ready: with EJECT_PENDING low, a new column wins over a same-cycle clear
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            COLUMN_READY <= 1'b0;
        end else if (CE) begin
            if (load && !EJECT_PENDING) begin
                COLUMN_READY <= 1'b1;
            end else if (data_acc) begin
                COLUMN_READY <= 1'b0;
            end
        end
    end

    ccb_zone_encoder u_enc (
        .zones_lo (buf_q[ccb_pkg::LO_ZONES-1:0]),
        .code     (enc)
    );

    // read path
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            HOST_RDATA  <= ccb_pkg::DATA_RST;
            HOST_RVALID <= 1'b0;
        end else if (CE) begin
            HOST_RVALID <= HOST_RD;
            if (HOST_RD) begin
                case (HOST_ADDR)
                    ccb_pkg::ADDR_IMAGE: begin
                        HOST_RDATA <= {4'h0, buf_q};
                    end
                    ccb_pkg::ADDR_COMP: begin
                        HOST_RDATA <= {8'h00,
                            buf_q[ccb_pkg::ZONE_W-1 -: ccb_pkg::HI_ZONES],
                            enc};
                    end
                    ccb_pkg::ADDR_MAINT: begin
                        HOST_RDATA <= {12'h000, maint_q};
                    end
                    default: begin
                        HOST_RDATA <= ccb_pkg::DATA_RST;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            MAINT_OUT <= ccb_pkg::MAINT_RST;
        end else if (CE) begin
            MAINT_OUT <= maint_q;
        end
    end
endmodule : ccb_column_buffer

/* File: tb/ccb_column_buffer_assertions.sv */
/* port checker for the column buffer.
   assumes one clock and a bind onto the top module. */
`timescale 1ns/1ps
module ccb_column_buffer_assertions (
    input wire logic        SYS_CLK,
    input wire logic        RST,
    input wire logic        CE,
    input wire logic        OVERRUN_ERROR,
    input wire logic        EJECT_PENDING,
    input wire logic        HOST_RD,
    input wire logic        HOST_WR,
    input wire logic [1:0]  HOST_ADDR,
    input wire logic [15:0] HOST_WDATA,
    input wire logic [15:0] HOST_RDATA,
    input wire logic        HOST_RVALID,
    input wire logic        COLUMN_READY,
    input wire logic [3:0]  MAINT_OUT
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    rd_answer_a: assert property (CE && HOST_RD |=> HOST_RVALID) else $error("no answer");
    rv_cause_a: assert property (HOST_RVALID |-> $past(CE && HOST_RD)) else $error("stray");
    img_width_a: assert property (HOST_RVALID && $past(HOST_ADDR) == 2'h0
        |-> HOST_RDATA[15:12] == 4'h0) else $error("image wide");
    comp_width_a: assert property (HOST_RVALID && $past(HOST_ADDR) == 2'h1
        |-> HOST_RDATA[15:8] == 8'h00) else $error("byte wide");
    ready_set_a: assert property ($rose(COLUMN_READY)
        |-> !$past(OVERRUN_ERROR) && !$past(EJECT_PENDING)) else $error("bad set");
    ready_clear_a: assert property ($fell(COLUMN_READY)
        |-> $past(CE && HOST_RD && HOST_ADDR < 2'h2)) else $error("bad clear");
    ready_keep_a: assert property (COLUMN_READY && !(CE && HOST_RD && HOST_ADDR < 2'h2)
        |=> COLUMN_READY) else $error("ready lost");
    maint_copy_a: assert property (CE && HOST_WR && HOST_ADDR == 2'h2 ##1 CE
        |=> MAINT_OUT == $past(HOST_WDATA[3:0], 2)) else $error("maint");
endmodule : ccb_column_buffer_assertions
bind ccb_column_buffer ccb_column_buffer_assertions u_chk (.*);

/* File: tb/ccb_reader_model.sv */
/* reader mechanism model: zones, then column strobe.
   assumes the caller starts just after a clock edge. */
`timescale 1ns/1ps
module ccb_reader_model (
    input wire logic  clk,
    output logic [11:0] zones,
    output logic      strobe
);
    initial begin
        zones = 12'h000;
        strobe = 1'b0;
    end
    task automatic send(input logic [11:0] c);
        zones = c;
        repeat (3) @(posedge clk); // settle first
        #2 strobe = 1'b1;
        repeat (2) @(posedge clk);
        #2 strobe = 1'b0;
        repeat (3) @(posedge clk);
        #2 zones = ~c;
    endtask : send
endmodule : ccb_reader_model

/* File: tb/ccb_column_buffer_tb.sv */
/* bench for the column buffer.
   assumes the reader model and bound checker. */
`timescale 1ns/1ps
module ccb_column_buffer_tb;
    logic SYS_CLK = 1'b0, RST = 1'b1, CE = 1'b1, HOST_RD = 1'b0, HOST_WR = 1'b0;
    logic OVERRUN_ERROR = 1'b0, EJECT_PENDING = 1'b0, COLUMN_STROBE, HOST_RVALID, COLUMN_READY;
    logic [1:0] HOST_ADDR = 2'h0;
    logic [15:0] HOST_WDATA = 16'h0000, HOST_RDATA;
    logic [11:0] ZONE_IN;
    logic [3:0] MAINT_OUT;
    int errors = 0, num_checks = 0, cyc = 0;
    ccb_column_buffer dut (.*);
    ccb_reader_model rdr (.clk(SYS_CLK), .zones(ZONE_IN), .strobe(COLUMN_STROBE));
    initial forever #12.5 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [1:0] a, input logic [15:0] exp);
        HOST_ADDR = a;
        HOST_RD = 1'b1;
        @(posedge SYS_CLK);
        #2 HOST_RD = 1'b0;
        chk({15'h0000, HOST_RVALID}, 16'h0001);
        chk(HOST_RDATA, exp);
        @(posedge SYS_CLK);
        #2;
    endtask : rd
    task automatic col(input logic [11:0] c, input logic rdy, input logic [11:0] img);
        rdr.send(c);
        chk({15'h0000, COLUMN_READY}, {15'h0000, rdy});
        rd(2'h0, {4'h0, img});
        chk({15'h0000, COLUMN_READY}, 16'h0000);
    endtask : col
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict
    initial begin
        logic [11:0] c;
        repeat (20) @(posedge SYS_CLK);
        #2 RST = 1'b0;
        chk(HOST_RDATA, 16'h0000);
        chk({11'h000, COLUMN_READY, MAINT_OUT}, 16'h0000);
        for (int k = 0; k < 8; k++) begin
            c = {5'(k * 3 + 1), (k == 0) ? 7'h00 : 7'(7'h40 >> (k - 1))};
            col(c, 1'b1, c);
            rd(2'h1, {8'h00, c[11:7], 3'(k)});
        end
        rdr.send(12'h801);
        rd(2'h1, 16'h0087);
        chk({15'h0000, COLUMN_READY}, 16'h0000);
        $display("test columns done");
        OVERRUN_ERROR = 1'b1;
        col(12'hABC, 1'b0, 12'h801);
        OVERRUN_ERROR = 1'b0;
        EJECT_PENDING = 1'b1;
        col(12'h5A5, 1'b0, 12'h5A5);
        EJECT_PENDING = 1'b0;
        $display("test blocking done");
        HOST_ADDR = 2'h2;
        HOST_WDATA = 16'h3C63;
        HOST_WR = 1'b1;
        @(posedge SYS_CLK);
        #2 HOST_WR = 1'b0;
        repeat (2) @(posedge SYS_CLK);
        #2 chk({12'h000, MAINT_OUT}, 16'h0003);
        chk({15'h0000, COLUMN_READY}, 16'h0001);
        rd(2'h0, 16'h03C6);
        rd(2'h2, 16'h0003);
        rd(2'h3, 16'h0000);
        $display("test maintenance done");
        HOST_ADDR = 2'h2;
        HOST_WDATA = 16'h0013;
        HOST_WR = 1'b1;
        @(posedge SYS_CLK);
        #2 HOST_WR = 1'b0;
        @(posedge SYS_CLK);
        #2 CE = 1'b0;
        HOST_ADDR = 2'h0;
        HOST_RD = 1'b1;
        @(posedge SYS_CLK);
        #2 HOST_RD = 1'b0;
        chk({15'h0000, HOST_RVALID}, 16'h0000);
        chk({15'h0000, COLUMN_READY}, 16'h0001);
        @(posedge SYS_CLK);
        #2 CE = 1'b1;
        rd(2'h1, 16'h0007);
        chk({15'h0000, COLUMN_READY}, 16'h0000);
        $display("test clock enable done");
        print_verdict();
    end
endmodule : ccb_column_buffer_tb
